//--- sbc_axil_slave.sv
// axi4-lite slave handshake, one write and one read in flight
`timescale 1ns/1ps
`default_nettype none
module sbc_axil_slave
   import sbc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [SBC_AW-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [SBC_AW-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   output sbc_wr_t wr_req,
   output logic wr_fire,
   input wire logic wr_err,
   output logic rd_fire,
   output logic [SBC_AW-1:0] rd_addr,
   input wire logic [31:0] rd_data,
   input wire logic rd_err
);
   logic aw_full; // address captured
   logic w_full;  // data captured

   // commit once both halves are held and no answer is pending
   assign wr_fire = aw_full && w_full && !bvalid;
   assign rd_fire = arvalid && arready;
   assign rd_addr = araddr;

   ////////////////////////////////////////////////////////////////////
   // write channels: address and data taken in either order
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         awready <= 1'b1;
         wready <= 1'b1;
         aw_full <= 1'b0;
         w_full <= 1'b0;
         bvalid <= 1'b0;
         bresp <= SBC_RESP_OKAY;
         wr_req <= '0;
      end
      else
      begin
         if (awvalid && awready)
         begin
            wr_req.addr <= awaddr;
            aw_full <= 1'b1;
            awready <= 1'b0;
         end
         if (wvalid && wready)
         begin
            wr_req.data <= wdata;
            wr_req.strb <= wstrb;
            w_full <= 1'b1;
            wready <= 1'b0;
         end
         if (wr_fire)
         begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            bvalid <= 1'b1;
            bresp <= wr_err ? SBC_RESP_DECERR : SBC_RESP_OKAY;
         end
         // readies return only after the answer is taken
         if (bvalid && bready)
         begin
            bvalid <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // read channels: data sampled at the address handshake
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= 32'h00000000;
         rresp <= SBC_RESP_OKAY;
      end
      else
      begin
         if (rd_fire)
         begin
            rdata <= rd_data;
            rresp <= rd_err ? SBC_RESP_DECERR : SBC_RESP_OKAY;
            rvalid <= 1'b1;
            arready <= 1'b0;
         end
         if (rvalid && rready)
         begin
            rvalid <= 1'b0;
            arready <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

//--- sbc_cascade_stage.sv
// behavioural upper counter stage fed by the terminal count carry
`timescale 1ns/1ps
`default_nettype none
module sbc_cascade_stage
   import sbc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic clr_n,
   input wire logic carry_in,
   input wire logic cnt_en,
   output logic [SBC_CNT_W-1:0] upper_count
);
   always_ff @(posedge clk or posedge rst or negedge clr_n)
   begin
      if (rst || !clr_n)
         upper_count <= SBC_CNT_RST;
      else if (carry_in && cnt_en)
         upper_count <= upper_count + 4'h1;
   end
endmodule
`default_nettype wire

//--- sbc_counter_props.sv
// concurrent checks on the counter pins of the top module
`timescale 1ns/1ps
`default_nettype none
module sbc_counter_props
   import sbc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic master_clear_n,
   input wire logic load_enable_n,
   input wire logic count_enable_parallel,
   input wire logic count_enable_trickle,
   input wire logic [SBC_CNT_W-1:0] load_data_in,
   input wire logic [SBC_CNT_W-1:0] count_value_out,
   input wire logic terminal_count_out,
   input wire logic awvalid,
   input wire logic awready
);
   // cycles left in which a register write may still move the count
   logic [2:0] sw_win_reg;
   // no bus write nearby
   logic quiet;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // a software load lands a few edges after the write, so pin checks wait
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         sw_win_reg <= 3'h0;
      else if (awvalid && awready)
         sw_win_reg <= 3'h6;
      else if (sw_win_reg != 3'h0)
         sw_win_reg <= sw_win_reg - 3'h1;
   end
   assign quiet = (sw_win_reg == 3'h0) && !awvalid;
   ////////////////////////////////////////////////////////////////////////
   // counting edge with nothing of higher priority
   sequence s_count_go;
      master_clear_n && load_enable_n && count_enable_parallel &&
         count_enable_trickle && quiet;
   endsequence
   // clear still released at the following edge
   sequence s_run_next;
      ##1 master_clear_n;
   endsequence
   a_count_up: assert property (s_count_go ##0 s_run_next |->
      count_value_out == $past(count_value_out) + 4'h1)
      else $error("count did not advance by one");
   a_wrap_zero: assert property (s_count_go ##0
      count_value_out == SBC_CNT_MAX |-> terminal_count_out ##1
      (!master_clear_n || (count_value_out == 4'h0 && !terminal_count_out)))
      else $error("count did not wrap from top to zero");
   a_load_pins: assert property (master_clear_n && !load_enable_n
      ##0 s_run_next |-> count_value_out == $past(load_data_in))
      else $error("parallel load value not taken");
   a_hold_count: assert property (master_clear_n && load_enable_n &&
      quiet && !(count_enable_parallel && count_enable_trickle) ##0
      s_run_next |-> $stable(count_value_out))
      else $error("count moved while a count enable was low");
   a_clear_now: assert property (!master_clear_n |->
      count_value_out == SBC_CNT_RST && !terminal_count_out)
      else $error("count not zero during master clear");
   a_tc_decode: assert property (terminal_count_out ==
      (&count_value_out && count_enable_trickle))
      else $error("terminal count decode wrong");
   a_clear_release: assert property ($rose(master_clear_n) |->
      count_value_out == SBC_CNT_RST)
      else $error("count not zero on clear release");
   a_trickle_gate: assert property (!count_enable_trickle |->
      !terminal_count_out)
      else $error("terminal count high with trickle low");
endmodule
bind sbc_counter_top sbc_counter_props sbc_counter_props_i (
   .clk(clk), .rst(rst), .master_clear_n(master_clear_n),
   .load_enable_n(load_enable_n),
   .count_enable_parallel(count_enable_parallel),
   .count_enable_trickle(count_enable_trickle),
   .load_data_in(load_data_in), .count_value_out(count_value_out),
   .terminal_count_out(terminal_count_out), .awvalid(awvalid),
   .awready(awready));
`default_nettype wire

//--- sbc_counter_top.sv
// 4-bit synchronous binary counter with load, enables and register view
//
// Behaviour
// - four-bit count held on flip-flop outputs
// - count up in binary, 15 wraps to 0
// - count changes on rising clock edge, or at once on master clear
// - priority: clear, load, count, then hold
// - low master clear zeroes count immediately
// - low load enable copies data, ignores enables
// - increment only when both enables high
// - either enable low holds the count
// - controls other than master clear sampled only at rising clock edge
// - terminal count is trickle AND count 15
`timescale 1ns/1ps
`default_nettype none
module sbc_counter_top
   import sbc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   // counter pins
   input wire logic master_clear_n,
   input wire logic load_enable_n,
   input wire logic count_enable_parallel,
   input wire logic count_enable_trickle,
   input wire logic [SBC_CNT_W-1:0] load_data_in,
   output logic [SBC_CNT_W-1:0] count_value_out,
   output logic terminal_count_out,
   // axi4-lite register port
   input wire logic [SBC_AW-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [SBC_AW-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready
);

   ////////////////////////////////////////////////////////////////////
   // declarations

   // count state and its next value
   logic [SBC_CNT_W-1:0] count_reg;
   logic [SBC_CNT_W-1:0] count_next;

   // resolved mode for this edge
   sbc_mode_t mode;

   // pin bundle handed to the resolver
   sbc_pins_t pins;

   // software preset value and one-shot load request
   logic [SBC_CNT_W-1:0] load_val_reg;
   logic sw_load_reg;

   // sticky status flags, cleared by writing one
   logic wrap_seen_reg;
   logic load_seen_reg;

   // running number of wraps, saturates never, rolls over
   logic [SBC_WRAP_W-1:0] wrap_cnt_reg;

   // events seen at this edge
   logic wrap_evt;
   logic load_evt;

   // decoded bus traffic
   sbc_wr_t wr_req;
   logic wr_fire;
   logic wr_err;
   logic rd_fire;
   logic [SBC_AW-1:0] rd_addr;
   logic [31:0] rd_data;
   logic rd_err;

   // per-register write selects
   logic wr_ctrl;
   logic wr_load;
   logic wr_stat;

   // clear requests from a status write
   logic clr_wrap;
   logic clr_load;

   // terminal count term before the output
   logic tc_term;

   ////////////////////////////////////////////////////////////////////
   // bus slave

   // handshake engine; only the decode lives here
   sbc_axil_slave u_bus (
      .clk(clk),
      .rst(rst),
      .awaddr(awaddr),
      .awvalid(awvalid),
      .awready(awready),
      .wdata(wdata),
      .wstrb(wstrb),
      .wvalid(wvalid),
      .wready(wready),
      .bresp(bresp),
      .bvalid(bvalid),
      .bready(bready),
      .araddr(araddr),
      .arvalid(arvalid),
      .arready(arready),
      .rdata(rdata),
      .rresp(rresp),
      .rvalid(rvalid),
      .rready(rready),
      .wr_req(wr_req),
      .wr_fire(wr_fire),
      .wr_err(wr_err),
      .rd_fire(rd_fire),
      .rd_addr(rd_addr),
      .rd_data(rd_data),
      .rd_err(rd_err)
   );

   ////////////////////////////////////////////////////////////////////
   // mode resolution

   // bundle the synchronous pins; all are sampled at the edge only;
   // one assignment keeps the bundle a single-driver variable
   assign pins = {load_enable_n, count_enable_parallel,
                  count_enable_trickle, load_data_in};

   sbc_mode_sel u_mode (
      .pins(pins),
      .sw_load(sw_load_reg),
      .sw_data(load_val_reg),
      .cnt(count_reg),
      .mode(mode),
      .cnt_next(count_next)
   );

   // a wrap is a count step taken from the top value
   assign wrap_evt = (mode == SBC_MODE_COUNT) &&
                     (count_reg == SBC_CNT_MAX);

   // any parallel load from the pins; a load shadowed by master
   // clear never reaches the count, so it is not recorded
   assign load_evt = (mode == SBC_MODE_LOAD) && master_clear_n;

   ////////////////////////////////////////////////////////////////////
   // count register

   // master clear is a second asynchronous clear beside rst;
   // it wins over every synchronous mode while it is low
   // asynchronous clear
   always_ff @(posedge clk or posedge rst or negedge master_clear_n)
   begin
      if (rst || !master_clear_n)
         count_reg <= SBC_CNT_RST;
      else
         count_reg <= count_next;
   end

   assign count_value_out = count_reg;

   ////////////////////////////////////////////////////////////////////
   // terminal count

   // kept as a gate so that cascades see the trickle enable at once;
   // a registered copy would lag the enable by one clock and break
   // both ripple and lookahead chaining
   // trickle and all-ones
   assign tc_term = (&count_reg) && count_enable_trickle;

   // decode glitches are possible, so it is not for clocking
   // data use only
   assign terminal_count_out = tc_term;

   ////////////////////////////////////////////////////////////////////
   // write decode

   // only aligned word offsets in the map are accepted
   always_comb
   begin
      wr_ctrl = 1'b0;
      wr_load = 1'b0;
      wr_stat = 1'b0;
      wr_err = 1'b0;
      case (wr_req.addr)
         SBC_CTRL_OFS: wr_ctrl = 1'b1;
         SBC_LOAD_OFS: wr_load = 1'b1;
         SBC_STAT_OFS: wr_stat = 1'b1;
         // wrap counter is read only, writes are dropped quietly
         SBC_WRAP_OFS: wr_err = 1'b0;
         // unmapped offset answers with a decode error
         default: wr_err = 1'b1;
      endcase
   end

   // status clears need a committed write with the low lane
   assign clr_wrap = wr_fire && wr_stat && wr_req.strb[0] &&
                     wr_req.data[SBC_STAT_WRAP_BIT];
   assign clr_load = wr_fire && wr_stat && wr_req.strb[0] &&
                     wr_req.data[SBC_STAT_LDSEEN_BIT];

   ////////////////////////////////////////////////////////////////////
   // software preset value

   // only the low byte lane carries the preset
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         load_val_reg <= SBC_LOAD_RST;
      else if (wr_fire && wr_load && wr_req.strb[0])
         load_val_reg <= wr_req.data[SBC_CNT_W-1:0];
   end

   ////////////////////////////////////////////////////////////////////
   // software load request

   // one-cycle request, acted on at the edge after the write;
   // a pin load at that edge wins and the request is spent anyway
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         sw_load_reg <= 1'b0;
      else if (wr_fire && wr_ctrl && wr_req.strb[0])
         sw_load_reg <= wr_req.data[SBC_CTRL_SWLD_BIT];
      else
         sw_load_reg <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////
   // sticky wrap flag

   // a wrap in the clearing cycle keeps the flag set
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         wrap_seen_reg <= 1'b0;
      else if (wrap_evt)
         wrap_seen_reg <= 1'b1;
      else if (clr_wrap)
         wrap_seen_reg <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////
   // sticky pin-load flag

   // same set-wins ordering as the wrap flag
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         load_seen_reg <= 1'b0;
      else if (load_evt)
         load_seen_reg <= 1'b1;
      else if (clr_load)
         load_seen_reg <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////
   // wrap counter

   // counts whole modulo-16 cycles; master clear leaves it alone
   // so software can still see history across a clear
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         wrap_cnt_reg <= SBC_WRAP_RST;
      else if (wrap_evt)
         wrap_cnt_reg <= wrap_cnt_reg + 16'h0001;
   end

   ////////////////////////////////////////////////////////////////////
   // read decode

   // unused upper bits read as zero
   always_comb
   begin
      rd_data = 32'h00000000;
      rd_err = 1'b0;
      case (rd_addr)
         SBC_CTRL_OFS:
         begin
            // load request reads back while pending
            rd_data[SBC_CTRL_SWLD_BIT] = sw_load_reg;
         end
         SBC_LOAD_OFS:
         begin
            rd_data[SBC_CNT_W-1:0] = load_val_reg;
         end
         SBC_STAT_OFS:
         begin
            // live count, flags and clear level
            rd_data[SBC_CNT_W-1:0] = count_reg;
            rd_data[SBC_STAT_TC_BIT] = tc_term;
            rd_data[SBC_STAT_WRAP_BIT] = wrap_seen_reg;
            rd_data[SBC_STAT_MCLR_BIT] = !master_clear_n;
            rd_data[SBC_STAT_LDSEEN_BIT] = load_seen_reg;
         end
         SBC_WRAP_OFS:
         begin
            rd_data[SBC_WRAP_W-1:0] = wrap_cnt_reg;
         end
         default:
         begin
            // unmapped read answers zero with an error
            rd_err = 1'b1;
         end
      endcase
   end

   // rd_fire only marks the sample point inside the slave
   // cascade wiring is left to the surrounding logic
   // the cascade and the status TC bit both depend on the trickle-gated terminal count above

endmodule
`default_nettype wire

//--- sbc_counter_top_tb.sv
// self-checking bench for the 4-bit counter and its register port
`timescale 1ns/1ps
`default_nettype none
module sbc_counter_top_tb
   import sbc_pkg::*;
;
   logic clk = 1'b0, rst = 1'b1, master_clear_n = 1'b1;
   logic load_enable_n = 1'b1, count_enable_parallel = 1'b0;
   logic count_enable_trickle = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
   logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [3:0] load_data_in = 4'h0, awaddr = 4'h0, araddr = 4'h0;
   logic [3:0] wstrb = 4'hF, count_value_out, upper_count;
   logic [31:0] wdata = 32'h0, rdata;
   logic terminal_count_out, awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   int num_errors = 0, n_tests = 0, cycles = 0;
   // 4 ns period
   always #2 clk = ~clk;
   sbc_counter_top sbc_counter_top_i (.clk(clk), .rst(rst),
      .master_clear_n(master_clear_n), .load_enable_n(load_enable_n),
      .count_enable_parallel(count_enable_parallel),
      .count_enable_trickle(count_enable_trickle),
      .load_data_in(load_data_in), .count_value_out(count_value_out),
      .terminal_count_out(terminal_count_out), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready));
   // first-stage carry gates the upper stage directly
   sbc_cascade_stage sbc_cascade_stage_i (.clk(clk), .rst(rst),
      .clr_n(master_clear_n), .carry_in(terminal_count_out),
      .cnt_en(count_enable_parallel), .upper_count(upper_count));
   ////////////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      if (num_errors == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // whole run is under two hundred cycles; a hang stops here
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 4000)
      begin
         num_errors++;
         end_of_test();
      end
   end
   task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
      n_tests++;
      if (got !== exp)
      begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one pin setting for one edge, then back to hold; check at negedge
   task automatic tick(input logic ld_n, input logic pe, input logic te,
      input logic [3:0] d);
      @(posedge clk);
      load_enable_n <= ld_n;
      count_enable_parallel <= pe;
      count_enable_trickle <= te;
      load_data_in <= d;
      @(posedge clk);
      load_enable_n <= 1'b1;
      count_enable_parallel <= 1'b0;
      @(negedge clk);
   endtask
   // bus write: address and data offered together, released when taken
   task automatic bus_wr(input logic [3:0] a, input logic [31:0] d,
      input logic [1:0] exp);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge clk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      chk("bresp", 32'(exp), 32'(bresp));
   endtask
   task automatic bus_rd(input logic [3:0] a, input logic [31:0] exp,
      input logic [1:0] rexp);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge clk);
         if (arready)
            arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
      chk("rdata", exp, rdata);
      chk("rresp", 32'(rexp), 32'(rresp));
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      chk("count", 32'h0, 32'(count_value_out));
      chk("tc", 32'h0, 32'(terminal_count_out));
      bus_rd(SBC_LOAD_OFS, 32'h0, SBC_RESP_OKAY);
      bus_rd(SBC_WRAP_OFS, 32'h0, SBC_RESP_OKAY);
   endtask
   // every value loads, enables high are ignored
   task automatic t_load();
      for (int i = 0; i < 16; i++)
      begin
         tick(1'b0, 1'b1, 1'b1, 4'(i));
         chk("count", 32'(i), 32'(count_value_out));
      end
   endtask
   task automatic t_hold();
      tick(1'b0, 1'b0, 1'b0, 4'h6);
      for (int k = 0; k < 3; k++)
      begin
         tick(1'b1, k[1], k[0], 4'h0);
         chk("count", 32'h6, 32'(count_value_out));
      end
   endtask
   task automatic t_wrap();
      tick(1'b0, 1'b0, 1'b1, 4'hE);
      tick(1'b1, 1'b1, 1'b1, 4'h0);
      chk("count", 32'hF, 32'(count_value_out));
      chk("tc", 32'h1, 32'(terminal_count_out));
      tick(1'b1, 1'b1, 1'b1, 4'h0);
      chk("count", 32'h0, 32'(count_value_out));
      chk("tc", 32'h0, 32'(terminal_count_out));
      chk("upper", 32'h1, 32'(upper_count));
   endtask
   // clear lands without an edge and beats a pending load
   task automatic t_clear();
      tick(1'b0, 1'b0, 1'b0, 4'h9);
      @(posedge clk);
      master_clear_n <= 1'b0;
      load_enable_n <= 1'b0;
      load_data_in <= 4'h3;
      #1;
      chk("count", 32'h0, 32'(count_value_out));
      @(posedge clk);
      #1;
      chk("count", 32'h0, 32'(count_value_out));
      chk("tc", 32'h0, 32'(terminal_count_out));
      @(posedge clk);
      master_clear_n <= 1'b1;
      @(posedge clk);
      load_enable_n <= 1'b1;
      @(negedge clk);
      chk("count", 32'h3, 32'(count_value_out));
   endtask
   task automatic t_regs();
      bus_wr(SBC_LOAD_OFS, 32'h5, SBC_RESP_OKAY);
      bus_rd(SBC_LOAD_OFS, 32'h5, SBC_RESP_OKAY);
      bus_wr(SBC_CTRL_OFS, 32'h1, SBC_RESP_OKAY);
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk("count", 32'h5, 32'(count_value_out));
      bus_rd(SBC_WRAP_OFS, 32'h1, SBC_RESP_OKAY);
      bus_wr(4'h2, 32'h0, SBC_RESP_DECERR);
      bus_rd(4'h2, 32'h0, SBC_RESP_DECERR);
   endtask
   // status fields, write-one-to-clear flags, clear level bit
   task automatic t_status();
      bus_rd(SBC_STAT_OFS, 32'hA5, SBC_RESP_OKAY);
      bus_wr(SBC_STAT_OFS, 32'hA0, SBC_RESP_OKAY);
      bus_rd(SBC_STAT_OFS, 32'h05, SBC_RESP_OKAY);
      tick(1'b0, 1'b0, 1'b1, 4'hF);
      bus_rd(SBC_STAT_OFS, 32'h9F, SBC_RESP_OKAY);
      @(posedge clk);
      master_clear_n <= 1'b0;
      bus_rd(SBC_STAT_OFS, 32'hC0, SBC_RESP_OKAY);
      bus_rd(SBC_WRAP_OFS, 32'h1, SBC_RESP_OKAY);
      master_clear_n <= 1'b1;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_load();
      t_hold();
      t_wrap();
      t_clear();
      t_regs();
      t_status();
      end_of_test();
   end
endmodule
`default_nettype wire

//--- sbc_mode_sel.sv
// mode priority resolver and next-count generator
`timescale 1ns/1ps
`default_nettype none
module sbc_mode_sel
   import sbc_pkg::*;
(
   input wire sbc_pins_t pins,
   input wire logic sw_load,
   input wire logic [SBC_CNT_W-1:0] sw_data,
   input wire logic [SBC_CNT_W-1:0] cnt,
   output sbc_mode_t mode,
   output logic [SBC_CNT_W-1:0] cnt_next
);
   // fixed precedence below the asynchronous clear
   always_comb
   begin
      if (!pins.load_enable_n)
         mode = SBC_MODE_LOAD;
      else if (sw_load)
         mode = SBC_MODE_SWLOAD;
      else if (pins.count_enable_parallel && pins.count_enable_trickle)
         mode = SBC_MODE_COUNT;
      else
         mode = SBC_MODE_HOLD;
   end

   // value the counter takes at the next edge
   always_comb
   begin
      case (mode)
         SBC_MODE_LOAD: cnt_next = pins.load_data_in;
         SBC_MODE_SWLOAD: cnt_next = sw_data;
         // natural wrap of the 4-bit sum, 15 goes to 0
         SBC_MODE_COUNT: cnt_next = cnt + 4'h1;
         SBC_MODE_HOLD: cnt_next = cnt;
         default: cnt_next = cnt;
      endcase
   end
endmodule
`default_nettype wire

//--- sbc_pkg.sv
// shared constants and types for the 4-bit synchronous binary counter
`default_nettype none
package sbc_pkg;
   // counter geometry
   localparam int SBC_CNT_W = 4;
   localparam logic [3:0] SBC_CNT_MAX = 4'hF;
   localparam logic [3:0] SBC_CNT_RST = 4'h0;
   // wrap event counter
   localparam int SBC_WRAP_W = 16;
   localparam logic [15:0] SBC_WRAP_RST = 16'h0000;
   // register bus geometry
   localparam int SBC_AW = 4;
   localparam logic [3:0] SBC_CTRL_OFS = 4'h0;
   localparam logic [3:0] SBC_LOAD_OFS = 4'h4;
   localparam logic [3:0] SBC_STAT_OFS = 4'h8;
   localparam logic [3:0] SBC_WRAP_OFS = 4'hC;
   // field positions
   localparam int SBC_CTRL_SWLD_BIT = 0;
   localparam int SBC_STAT_TC_BIT = 4;
   localparam int SBC_STAT_WRAP_BIT = 5;
   localparam int SBC_STAT_MCLR_BIT = 6;
   localparam int SBC_STAT_LDSEEN_BIT = 7;
   // reset values of software registers
   localparam logic [3:0] SBC_LOAD_RST = 4'h0;
   // bus responses
   localparam logic [1:0] SBC_RESP_OKAY = 2'h0;
   localparam logic [1:0] SBC_RESP_DECERR = 2'h3;
   // operating modes resolved at each rising edge
   typedef enum logic [1:0] {
      SBC_MODE_HOLD = 2'b00,
      SBC_MODE_COUNT = 2'b01,
      SBC_MODE_SWLOAD = 2'b10,
      SBC_MODE_LOAD = 2'b11
   } sbc_mode_t;
   // synchronous control pins as one bundle
   typedef struct packed {
      logic load_enable_n;
      logic count_enable_parallel;
      logic count_enable_trickle;
      logic [SBC_CNT_W-1:0] load_data_in;
   } sbc_pins_t;
   // one captured register write
   typedef struct packed {
      logic [SBC_AW-1:0] addr;
      logic [31:0] data;
      logic [3:0] strb;
   } sbc_wr_t;
endpackage
`default_nettype wire
